// ---- inc/bbiq_pkg.sv ----
// Notes on behaviour
// - device is master: makes bit clock and frame sync; five framing formats selectable
// - in-phase word on in_phase_data_out, quadrature word on quadrature_data_out, 16 bits each
// - one frame sync frames both words; both lines carry one sample per frame
// - i2s-style: msb on second rising bit clock edge after each sync transition, then down
// - left-justified: msb on first rising bit clock edge after each sync transition
// - right-justified: lsb on the last rising bit clock edge of each sync interval
// - dsp formats: frame sync is a pulse exactly one bit clock period wide
// - dsp: msb on first (left-justified variant) or second rising edge after the pulse
// - a setting moves capture to the falling bit clock edge; receiver samples there
// - digital reception sample rates 650, 675 or 744.1875 khz chosen by reference clock
// - 36.4 mhz ref: 650k/10.4m digital, 325k/5.2m fm, 40.625k/2.275m am
// - 37.8 mhz ref: 675k/10.8m digital, 337.5k/5.4m fm, 42.1875k/2.3625m am
// - 37.209375 mhz ref: 744.1875k/14.88375m digital, 372.0938k/7.4419m fm, 46.5117k/1.8605m am
// - stream carries 500 khz bandwidth for fm and 30 khz for am
// - bit clock, frame sync and both data lines are driven on their own outputs
package bbiq_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

  // control register layout
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FMT = 1;
  localparam int FMT_W = 3;
  localparam int CTRL_FALL = 4;
  localparam int CTRL_REF = 5;
  localparam int CTRL_MODE = 7;
  localparam int SEL_W = 2;
  localparam int CTRL_AM = 9;

  // status register layout
  localparam int ST_UNDERRUN = 0;
  localparam int ST_RUN = 1;
  localparam int ST_FMT = 2;
  localparam int ST_FALL = 5;
  localparam int ST_BW = 16;
  localparam int BW_W = 10;
  localparam logic [BW_W-1:0] BW_FM_KHZ = 10'h1f4;
  localparam logic [BW_W-1:0] BW_AM_KHZ = 10'h01e;

  typedef enum logic [FMT_W-1:0] {FMT_I2S, FMT_LJ, FMT_RJ, FMT_DSP, FMT_DSP_LJ} bbiq_fmt_t;

  // bit slot (counted from the frame start) that carries the msb, and the slot that carries the dsp sync pulse
  localparam logic [CNT_W-1:0] I2S_MSB_SLOT = 8'h01;
  localparam logic [CNT_W-1:0] LJ_MSB_SLOT = 8'h00;
  localparam logic [CNT_W-1:0] DSP_MSB_SLOT = 8'h02;
  localparam logic [CNT_W-1:0] DSP_LJ_MSB_SLOT = 8'h01;
  localparam logic [CNT_W-1:0] DSP_PULSE_SLOT = 8'h00;

  // presets by reference (36.4, 37.8, 37.209375 mhz) x mode (digital, fm analog, am)
  localparam int N_PRESET = 9;
  localparam logic [SEL_W-1:0] MAX_SEL = 2'h2;
  localparam logic [3:0] SEL_STRIDE = 4'h3;
  // reference half-periods per bit clock period
  localparam logic [CNT_W-1:0] HALVES_PER_BIT [N_PRESET] = '{
    8'h07, 8'h0e, 8'h20, 8'h07, 8'h0e, 8'h20, 8'h05, 8'h0a, 8'h28};
  // bit clock periods per frame
  localparam logic [CNT_W-1:0] BITS_PER_FRAME [N_PRESET] = '{
    8'h10, 8'h10, 8'h38, 8'h10, 8'h10, 8'h38, 8'h14, 8'h14, 8'h28};

  function automatic logic [3:0] preset_idx(input logic [SEL_W-1:0] ref_sel, input logic [SEL_W-1:0] mode);
    logic [SEL_W-1:0] r;
    logic [SEL_W-1:0] m;
    r = (ref_sel > MAX_SEL) ? MAX_SEL : ref_sel;
    m = (mode > MAX_SEL) ? MAX_SEL : mode;
    preset_idx = 4'({2'h0, r} * SEL_STRIDE) + {2'h0, m};
  endfunction : preset_idx
endpackage : bbiq_pkg

// ---- logic/bbiq_clk_div.sv ----
module bbiq_clk_div #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [CNT_W-1:0] halves,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic rise;
    logic fall;
  } bbiq_div_state_t;

  bbiq_div_state_t q;
  bbiq_div_state_t n;

  // one tick per reference edge; high phase is halves/2 ticks, low phase the rest
  always_comb begin
    n = q;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (tick) begin
      if (q.cnt >= CNT_W'(halves - 1'b1)) begin
        n.cnt = '0;
        n.rise = 1'b1;
      end else begin
        n.cnt = CNT_W'(q.cnt + 1'b1);
        if (n.cnt == (halves >> 1)) begin
          n.fall = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rise = q.rise;
  assign fall = q.fall;
endmodule : bbiq_clk_div

// ---- logic/bbiq_pair_buf.sv ----
module bbiq_pair_buf #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [1:0] CNT_FULL = 2'h2;

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
    logic in_ready;
  } bbiq_buf_state_t;

  localparam bbiq_buf_state_t BUF_RST = '{mem: '0, wr: 1'b0, rd: 1'b0, cnt: CNT_EMPTY, in_ready: 1'b1};

  bbiq_buf_state_t q;
  bbiq_buf_state_t n;
  logic push;
  logic pop;

  always_comb begin
    n = q;
    push = in_valid && q.in_ready;
    pop = out_ready && (q.cnt != CNT_EMPTY);
    if (push) begin
      n.mem[q.wr] = in_data;
      n.wr = ~q.wr;
    end
    if (pop) begin
      n.rd = ~q.rd;
    end
    case ({push, pop})
      2'b10: n.cnt = 2'(q.cnt + 1'b1);
      2'b01: n.cnt = 2'(q.cnt - 1'b1);
      default: n.cnt = q.cnt;
    endcase
    // registered ready: stalls the source as soon as both entries hold words
    n.in_ready = (n.cnt != CNT_FULL);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= BUF_RST;
    end else begin
      q <= n;
    end
  end

  assign in_ready = q.in_ready;
  assign out_valid = (q.cnt != CNT_EMPTY);
  assign out_data = q.mem[q.rd];
endmodule : bbiq_pair_buf

// ---- logic/bbiq_serial_master.sv ----
module bbiq_serial_master #(
  parameter int WORD_W = bbiq_pkg::WORD_W,
  parameter int CNT_W = bbiq_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [bbiq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bbiq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bbiq_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reference_clock_in,
  input wire logic [WORD_W-1:0] in_phase_sample,
  input wire logic [WORD_W-1:0] quadrature_sample,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic sample_bit_clock,
  output logic sample_frame_sync,
  output logic in_phase_data_out,
  output logic quadrature_data_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] ref_sync;
    logic ref_prev;
    logic [bbiq_pkg::CTRL_W-1:0] ctrl;
    logic underrun;
    logic run;
    bbiq_pkg::bbiq_fmt_t fmt;
    logic fall;
    logic [CNT_W-1:0] halves;
    logic [CNT_W-1:0] nbits;
    logic [CNT_W-1:0] slot;
    logic bclk;
    logic fs;
    logic dout_i;
    logic dout_q;
    logic [WORD_W-1:0] sr_i;
    logic [WORD_W-1:0] sr_q;
    logic [bbiq_pkg::DATA_W-1:0] rdata;
  } bbiq_state_t;

  localparam bbiq_state_t ST_RST = '{
    ref_sync: 2'h0,
    ref_prev: 1'b0,
    ctrl: bbiq_pkg::CTRL_RST,
    underrun: 1'b0,
    run: 1'b0,
    fmt: bbiq_pkg::FMT_I2S,
    fall: 1'b0,
    halves: bbiq_pkg::HALVES_PER_BIT[0],
    nbits: bbiq_pkg::BITS_PER_FRAME[0],
    slot: '0,
    bclk: 1'b0,
    fs: 1'b0,
    dout_i: 1'b0,
    dout_q: 1'b0,
    sr_i: '0,
    sr_q: '0,
    rdata: '0
  };

  bbiq_state_t q;
  bbiq_state_t n;

  logic div_rise;
  logic div_fall;
  logic ref_edge;
  logic div_tick;
  logic [CNT_W-1:0] div_halves;
  logic buf_valid;
  logic [2*WORD_W-1:0] buf_data;
  logic pop;
  logic launch;
  logic start;
  logic boundary;
  logic underrun_set;
  logic underrun_clr;
  logic cfg_en;
  logic cfg_fall;
  bbiq_pkg::bbiq_fmt_t cfg_fmt;
  logic [3:0] cfg_idx;
  logic [CNT_W-1:0] nslot;
  logic [CNT_W-1:0] msb_slot;
  logic [bbiq_pkg::BW_W-1:0] bw_khz;
  logic [bbiq_pkg::DATA_W-1:0] status;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration decode

  always_comb begin
    cfg_en = q.ctrl[bbiq_pkg::CTRL_EN];
    cfg_fall = q.ctrl[bbiq_pkg::CTRL_FALL];
    // unused format codes fall back to the i2s-style framing
    if (q.ctrl[bbiq_pkg::CTRL_FMT +: bbiq_pkg::FMT_W] > bbiq_pkg::FMT_DSP_LJ) begin
      cfg_fmt = bbiq_pkg::FMT_I2S;
    end else begin
      cfg_fmt = bbiq_pkg::bbiq_fmt_t'(q.ctrl[bbiq_pkg::CTRL_FMT +: bbiq_pkg::FMT_W]);
    end
    cfg_idx = bbiq_pkg::preset_idx(q.ctrl[bbiq_pkg::CTRL_REF +: bbiq_pkg::SEL_W],
                                   q.ctrl[bbiq_pkg::CTRL_MODE +: bbiq_pkg::SEL_W]);
    bw_khz = q.ctrl[bbiq_pkg::CTRL_AM] ? bbiq_pkg::BW_AM_KHZ : bbiq_pkg::BW_FM_KHZ;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit clock divider and sample buffer

  assign ref_edge = q.ref_sync[1] ^ q.ref_prev;
  assign div_tick = ref_edge && (q.run || cfg_en);
  assign div_halves = q.run ? q.halves : bbiq_pkg::HALVES_PER_BIT[cfg_idx];

  bbiq_clk_div #(
    .CNT_W(CNT_W)
  ) u_div (
    .clk(clk),
    .resetn(resetn),
    .tick(div_tick),
    .halves(div_halves),
    .rise(div_rise),
    .fall(div_fall)
  );

  bbiq_pair_buf #(
    .W(2 * WORD_W)
  ) u_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(sample_valid),
    .in_data({in_phase_sample, quadrature_sample}),
    .in_ready(sample_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(pop)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // framing engine

  always_comb begin
    n = q;
    pop = 1'b0;
    underrun_set = 1'b0;
    nslot = '0;
    msb_slot = '0;
    boundary = 1'b0;
    n.ref_sync = {q.ref_sync[0], reference_clock_in};
    n.ref_prev = q.ref_sync[1];
    // data change on the edge opposite to the capture edge
    launch = (q.run ? q.fall : cfg_fall) ? div_rise : div_fall;
    start = launch && !q.run && cfg_en;
    if (q.run || start) begin
      if (div_rise) begin
        n.bclk = 1'b1;
      end
      if (div_fall) begin
        n.bclk = 1'b0;
      end
    end
    if (launch && (q.run || start)) begin
      boundary = start || (q.slot == CNT_W'(q.nbits - 1'b1));
      nslot = boundary ? '0 : CNT_W'(q.slot + 1'b1);
      if (boundary) begin
        if (!cfg_en) begin
          n.run = 1'b0;
          n.bclk = 1'b0;
          n.fs = 1'b0;
          n.slot = '0;
          n.sr_i = '0;
          n.sr_q = '0;
        end else begin
          n.run = 1'b1;
          n.fmt = cfg_fmt;
          n.fall = cfg_fall;
          n.halves = bbiq_pkg::HALVES_PER_BIT[cfg_idx];
          n.nbits = bbiq_pkg::BITS_PER_FRAME[cfg_idx];
        end
      end
      if (n.run) begin
        n.slot = nslot;
        case (n.fmt)
          bbiq_pkg::FMT_I2S: msb_slot = bbiq_pkg::I2S_MSB_SLOT;
          bbiq_pkg::FMT_LJ: msb_slot = bbiq_pkg::LJ_MSB_SLOT;
          bbiq_pkg::FMT_RJ: msb_slot = CNT_W'(n.nbits - WORD_W);
          bbiq_pkg::FMT_DSP: msb_slot = bbiq_pkg::DSP_MSB_SLOT;
          bbiq_pkg::FMT_DSP_LJ: msb_slot = bbiq_pkg::DSP_LJ_MSB_SLOT;
          default: msb_slot = bbiq_pkg::LJ_MSB_SLOT;
        endcase
        if (n.fmt == bbiq_pkg::FMT_DSP || n.fmt == bbiq_pkg::FMT_DSP_LJ) begin
          n.fs = (nslot == bbiq_pkg::DSP_PULSE_SLOT);
        end else if (boundary) begin
          n.fs = ~q.fs;
        end
        if (nslot == msb_slot) begin
          pop = 1'b1;
          if (buf_valid) begin
            n.sr_i = buf_data[WORD_W +: WORD_W];
            n.sr_q = buf_data[0 +: WORD_W];
          end else begin
            n.sr_i = '0;
            n.sr_q = '0;
            underrun_set = 1'b1;
          end
        end else begin
          // zeros fill the idle slots after the lsb
          n.sr_i = {q.sr_i[WORD_W-2:0], 1'b0};
          n.sr_q = {q.sr_q[WORD_W-2:0], 1'b0};
        end
      end
      n.dout_i = n.sr_i[WORD_W-1];
      n.dout_q = n.sr_q[WORD_W-1];
    end
    // register port
    if (reg_wr && reg_addr == bbiq_pkg::ADDR_CTRL) begin
      n.ctrl = reg_wdata[bbiq_pkg::CTRL_W-1:0];
    end
    underrun_clr = reg_wr && reg_addr == bbiq_pkg::ADDR_STATUS && reg_wdata[bbiq_pkg::ST_UNDERRUN];
    // a new underrun in the clearing cycle stays set
    n.underrun = underrun_set || (q.underrun && !underrun_clr);
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        bbiq_pkg::ADDR_CTRL: n.rdata = bbiq_pkg::DATA_W'(q.ctrl);
        bbiq_pkg::ADDR_STATUS: n.rdata = status;
        default: n.rdata = '0;
      endcase
    end
  end

  always_comb begin
    status = '0;
    status[bbiq_pkg::ST_UNDERRUN] = q.underrun;
    status[bbiq_pkg::ST_RUN] = q.run;
    status[bbiq_pkg::ST_FMT +: bbiq_pkg::FMT_W] = q.fmt;
    status[bbiq_pkg::ST_FALL] = q.fall;
    status[bbiq_pkg::ST_BW +: bbiq_pkg::BW_W] = bw_khz;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // all pins but sample_ready come straight from the state register; sample_ready comes from the buffer's register
  assign sample_bit_clock = q.bclk;
  assign sample_frame_sync = q.fs;
  assign in_phase_data_out = q.dout_i;
  assign quadrature_data_out = q.dout_q;
  assign reg_rdata = q.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_i2s_msb_slot: assert property (
    (pop ##1 q.fmt == bbiq_pkg::FMT_I2S) |-> q.slot == bbiq_pkg::I2S_MSB_SLOT)
    else $error("i2s msb not in second slot");

  a_lj_msb_slot: assert property (
    (pop ##1 q.fmt == bbiq_pkg::FMT_LJ) |-> q.slot == bbiq_pkg::LJ_MSB_SLOT)
    else $error("left-justified msb not in first slot");

  a_rj_word_end: assert property (
    (pop ##1 q.fmt == bbiq_pkg::FMT_RJ) |-> q.slot == CNT_W'(q.nbits - WORD_W))
    else $error("right-justified lsb does not end the interval");

  a_dsp_msb_slot: assert property (
    (pop ##1 q.fmt inside {bbiq_pkg::FMT_DSP, bbiq_pkg::FMT_DSP_LJ}) |->
      (q.fmt == bbiq_pkg::FMT_DSP) ? q.slot == bbiq_pkg::DSP_MSB_SLOT : q.slot == bbiq_pkg::DSP_LJ_MSB_SLOT)
    else $error("dsp msb in wrong slot");

  a_dsp_pulse_width: assert property (
    (q.run && q.fmt inside {bbiq_pkg::FMT_DSP, bbiq_pkg::FMT_DSP_LJ}) |->
      (q.fs == (q.slot == bbiq_pkg::DSP_PULSE_SLOT)))
    else $error("dsp frame sync not one bit wide");

  a_word_msb_out: assert property (
    (pop && buf_valid) |=> (q.dout_i == $past(buf_data[2*WORD_W-1])) && (q.dout_q == $past(buf_data[WORD_W-1])))
    else $error("sample msb not presented");

  a_level_fs_frame: assert property (
    (q.run && $past(q.run) && !(q.fmt inside {bbiq_pkg::FMT_DSP, bbiq_pkg::FMT_DSP_LJ}) && $changed(q.fs))
      |-> q.slot == '0)
    else $error("frame sync moved inside a frame");

  a_launch_edge: assert property (
    (q.run && $past(q.run) && $changed(q.dout_i)) |-> ($changed(q.bclk) && q.bclk == $past(q.fall)))
    else $error("data changed on the capture edge");

  a_cfg_boundary: assert property (
    ($changed(q.fmt) || $changed(q.fall)) |-> q.slot == '0)
    else $error("configuration changed mid frame");

  a_idle_quiet: assert property (
    !q.run |-> (!q.bclk && !q.fs && !q.dout_i && !q.dout_q))
    else $error("pins active while stopped");

  a_frame_length: assert property (
    q.run |-> q.slot < q.nbits)
    else $error("slot count beyond frame length");

  c_i2s_frame: cover property (q.run && q.fmt == bbiq_pkg::FMT_I2S && pop);
  c_dsp_frame: cover property (q.run && q.fmt == bbiq_pkg::FMT_DSP_LJ && $rose(q.fs));
  c_rj_fall: cover property (q.run && q.fmt == bbiq_pkg::FMT_RJ && q.fall && pop);
  c_underrun: cover property ($rose(q.underrun));
endmodule : bbiq_serial_master

// ---- verif/bbiq_iq_receiver.sv ----
module bbiq_iq_receiver (
  input wire logic sample_bit_clock,
  input wire logic sample_frame_sync,
  input wire logic in_phase_data_out,
  input wire logic quadrature_data_out,
  input wire logic [2:0] fmt,
  input wire logic fall,
  input wire logic [7:0] nbits,
  input wire logic clear,
  output logic [15:0] got_i,
  output logic [15:0] got_q,
  output logic [31:0] n_words
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fs_prev = 1'b0;
  logic [7:0] slot = 8'h00;
  logic [4:0] cnt = 5'h00;
  logic [15:0] sh_i = 16'h0000;
  logic [15:0] sh_q = 16'h0000;

  initial begin
    got_i = 16'h0000;
    got_q = 16'h0000;
    n_words = 32'h0;
  end

  function automatic logic [7:0] msb_slot(input logic [2:0] f, input logic [7:0] n);
    case (f)
      3'h1: msb_slot = 8'h00;
      3'h2: msb_slot = n - 8'h10;
      3'h3: msb_slot = 8'h02;
      3'h4: msb_slot = 8'h01;
      default: msb_slot = 8'h01;
    endcase
  endfunction : msb_slot

  task automatic take();
    if ((fmt >= 3'h3) ? sample_frame_sync : (sample_frame_sync != fs_prev)) begin
      slot = 8'h00;
    end else begin
      slot = slot + 8'h01;
    end
    fs_prev = sample_frame_sync;
    sh_i = {sh_i[14:0], in_phase_data_out};
    sh_q = {sh_q[14:0], quadrature_data_out};
    if (slot == msb_slot(fmt, nbits)) begin
      cnt = 5'h01;
    end else if (cnt != 5'h00) begin
      cnt = cnt + 5'h01;
    end
    // slots after the lsb are idle and ignored until the next msb slot
    if (cnt == 5'h10) begin
      got_i = sh_i;
      got_q = sh_q;
      n_words = n_words + 32'h1;
      cnt = 5'h00;
    end
  endtask : take

  always @(posedge sample_bit_clock) if (!fall) take();
  always @(negedge sample_bit_clock) if (fall) take();
  always @(posedge clear) begin
    fs_prev = 1'b0;
    cnt = 5'h00;
  end
endmodule : bbiq_iq_receiver

// ---- verif/bbiq_serial_master_tb.sv ----
module bbiq_serial_master_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic reference_clock_in = 1'b0;
  logic [7:0] src_k = 8'h00;
  logic src_on = 1'b0;
  logic sample_valid = 1'b0;
  logic sample_ready;
  logic sample_bit_clock;
  logic sample_frame_sync;
  logic in_phase_data_out;
  logic quadrature_data_out;
  logic [2:0] rx_fmt = 3'h0;
  logic rx_fall = 1'b0;
  logic [7:0] rx_nbits = 8'h10;
  logic rx_clear = 1'b0;
  logic [15:0] got_i;
  logic [15:0] got_q;
  logic [31:0] n_words;
  logic [31:0] rd;
  int n_fail = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;
  initial begin
    #17;
    forever #62.5 reference_clock_in = ~reference_clock_in;
  end

  // source of word pairs: i = {k, ~k}, q = {~k, k}, held until taken
  always @(posedge clk) begin
    if (sample_valid && sample_ready) src_k <= src_k + 8'h01;
    sample_valid <= src_on || (sample_valid && !sample_ready);
  end

  bbiq_serial_master u_bbiq_serial_master (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reference_clock_in(reference_clock_in), .in_phase_sample({src_k, ~src_k}),
    .quadrature_sample({~src_k, src_k}), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_bit_clock(sample_bit_clock), .sample_frame_sync(sample_frame_sync),
    .in_phase_data_out(in_phase_data_out), .quadrature_data_out(quadrature_data_out));

  bbiq_iq_receiver u_bbiq_iq_receiver (.sample_bit_clock(sample_bit_clock),
    .sample_frame_sync(sample_frame_sync), .in_phase_data_out(in_phase_data_out),
    .quadrature_data_out(quadrature_data_out), .fmt(rx_fmt), .fall(rx_fall), .nbits(rx_nbits),
    .clear(rx_clear), .got_i(got_i), .got_q(got_q), .n_words(n_words));

  ////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task timeout();
    n_fail++;
    $display("mismatch at %0t: wait ran out", $time);
    test_done();
  endtask : timeout

  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task wait_fs(input logic v, output time t);
    int i;
    for (i = 0; i < 3000 && sample_frame_sync !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 3000) timeout();
    t = $time;
  endtask : wait_fs

  task wait_bclk(input logic v, output time t);
    int i;
    for (i = 0; i < 3000 && sample_bit_clock !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 3000) timeout();
    t = $time;
  endtask : wait_bclk

  task stop_run();
    int i;
    reg_write(bbiq_pkg::ADDR_CTRL, 32'h0);
    rd = 32'h2;
    for (i = 0; i < 2000 && rd[1] !== 1'b0; i++) reg_read(bbiq_pkg::ADDR_STATUS, rd);
    if (i == 2000) timeout();
    check({28'h0, sample_bit_clock, sample_frame_sync, in_phase_data_out, quadrature_data_out},
          32'h0, "pins idle when stopped");
  endtask : stop_run

  task wait_word();
    int i;
    logic [31:0] w0;
    w0 = n_words;
    for (i = 0; i < 4000 && n_words == w0; i++) @(posedge clk);
    if (i == 4000) timeout();
  endtask : wait_word

  function automatic logic near(input time got, input real exp);
    near = (got > exp - 25.0) && (got < exp + 25.0);
  endfunction : near

  ////////////////////////////////////////
  task t_regs();
    reg_read(bbiq_pkg::ADDR_CTRL, rd);
    check(rd, 32'h0, "ctrl reset");
    reg_read(bbiq_pkg::ADDR_STATUS, rd);
    check(rd, {6'h00, bbiq_pkg::BW_FM_KHZ, 16'h0000}, "status reset");
    reg_write(bbiq_pkg::ADDR_CTRL, 32'h200);
    reg_read(bbiq_pkg::ADDR_STATUS, rd);
    check({22'h0, rd[25:16]}, {22'h0, bbiq_pkg::BW_AM_KHZ}, "am bandwidth");
    reg_write(4'hc, 32'hffff_ffff);
    reg_read(4'h8, rd);
    check(rd, 32'h0, "unmapped read");
    reg_read(bbiq_pkg::ADDR_CTRL, rd);
    check(rd, 32'h200, "ctrl after unmapped write");
    $display("test registers done");
  endtask : t_regs

  task t_fill();
    int i;
    src_on <= 1'b1;
    for (i = 0; i < 20 && sample_ready !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check({31'h0, sample_ready}, 32'h0, "buffer refuses when full");
    check({24'h0, src_k}, 32'h2, "two pairs held");
    $display("test buffer fill done");
  endtask : t_fill

  task run_fmt(input logic [2:0] f, input logic fl, input logic [1:0] rs, input logic [1:0] md,
               input logic [7:0] nb, input int halves);
    int i;
    logic [7:0] k;
    time t0;
    time t1;
    time t2;
    stop_run();
    rx_fmt <= f;
    rx_fall <= fl;
    rx_nbits <= nb;
    rx_clear <= 1'b1;
    @(posedge clk);
    rx_clear <= 1'b0;
    reg_write(bbiq_pkg::ADDR_CTRL, {23'h0, md, rs, fl, f, 1'b1});
    for (i = 0; i < 5; i++) begin
      wait_word();
      if (i == 0) k = got_i[15:8];
      check({16'h0, got_i}, {16'h0, k, ~k}, "i word");
      check({16'h0, got_q}, {16'h0, ~k, k}, "q word");
      k = k + 8'h01;
    end
    if (f >= 3'h3) begin
      wait_fs(1'b0, t0);
      wait_fs(1'b1, t0);
      wait_fs(1'b0, t1);
      wait_fs(1'b1, t2);
      check({31'h0, near(t1 - t0, halves * 62.5)}, 32'h1, "sync pulse width");
    end else begin
      wait_fs(~sample_frame_sync, t0);
      wait_fs(~sample_frame_sync, t2);
    end
    check({31'h0, near(t2 - t0, halves * nb * 62.5)}, 32'h1, "frame period");
    $display("test format %0d edge %0d done", f, fl);
  endtask : run_fmt

  task t_midframe();
    time t;
    wait_fs(~sample_frame_sync, t);
    reg_write(bbiq_pkg::ADDR_CTRL, 32'h1);
    reg_read(bbiq_pkg::ADDR_STATUS, rd);
    check({26'h0, rd[5:2]}, 32'ha, "format held mid frame");
    wait_fs(~sample_frame_sync, t);
    reg_read(bbiq_pkg::ADDR_STATUS, rd);
    check({26'h0, rd[5:2]}, 32'h0, "format taken at frame start");
    $display("test mid frame change done");
  endtask : t_midframe

  task t_underrun();
    int i;
    src_on <= 1'b0;
    rx_fmt <= 3'h0;
    rx_fall <= 1'b0;
    rd = 32'h0;
    for (i = 0; i < 3000 && rd[0] !== 1'b1; i++) reg_read(bbiq_pkg::ADDR_STATUS, rd);
    if (i == 3000) timeout();
    check({30'h0, rd[1:0]}, 32'h3, "underrun while running");
    wait_word();
    wait_word();
    check({got_i, got_q}, 32'h0, "zeros on underrun");
    src_on <= 1'b1;
    reg_write(bbiq_pkg::ADDR_STATUS, 32'h1);
    reg_read(bbiq_pkg::ADDR_STATUS, rd);
    check({31'h0, rd[0]}, 32'h0, "underrun cleared");
    $display("test underrun done");
  endtask : t_underrun

  task t_am();
    time t0;
    time t1;
    time t2;
    stop_run();
    // am mode on the first reference: 32 reference half-periods per bit
    reg_write(bbiq_pkg::ADDR_CTRL, 32'h101);
    wait_fs(1'b1, t0);
    wait_bclk(1'b1, t0);
    wait_bclk(1'b0, t1);
    wait_bclk(1'b1, t2);
    check({31'h0, near(t1 - t0, 16 * 62.5)}, 32'h1, "am bit clock high time");
    check({31'h0, near(t2 - t0, 32 * 62.5)}, 32'h1, "am bit clock period");
    $display("test am clock done");
  endtask : t_am

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_fill();
    run_fmt(3'h0, 1'b0, 2'h0, 2'h0, 8'd16, 7);
    run_fmt(3'h1, 1'b0, 2'h1, 2'h1, 8'd16, 14);
    run_fmt(3'h2, 1'b0, 2'h2, 2'h0, 8'd20, 5);
    run_fmt(3'h3, 1'b0, 2'h0, 2'h0, 8'd16, 7);
    run_fmt(3'h4, 1'b0, 2'h2, 2'h1, 8'd20, 10);
    run_fmt(3'h2, 1'b1, 2'h0, 2'h0, 8'd16, 7);
    t_midframe();
    t_underrun();
    t_am();
    test_done();
  end
endmodule : bbiq_serial_master_tb
